// [verilog/pirq_defs.svh]
// Notes on behaviour
// - Peripheral requests need the peripheral gate set
// - Enable one: eight enables, reset zero
// - Flags set regardless of any enable
// - Software clears flags before enabling them
// - EEPROM write done sets flag bit 7
// - Conversion done sets flag bit 6
// - Receive flag follows buffer full, read clears
// - Transmit flag follows buffer empty, write clears
// - Sync port completion sets flag bit 3
// - Capture/compare one sets bit 2 in capture or compare mode only
// - Timer two period match sets bit 1
// - Timer one overflow sets bit 0
// - Oscillator failover sets flag two bit 7
// - Comparator output changes set bits 6, 5
// - Display sets bit 4, low voltage bit 2
// - Capture/compare two at bit 0; 3,1 zero
// - Soft brown-out enable bit 4, resets one
// - Soft enable acts only when field is 01
// - Brown-out status cleared by brown-out reset
// - Global gate masks every interrupt
`ifndef PIRQ_DEFS_SVH
`define PIRQ_DEFS_SVH
// ==========================================
// Register offsets (word index, byte = 4x)
`define PIRQ_OFS_EN_ONE 3'h0
`define PIRQ_OFS_EN_TWO 3'h1
`define PIRQ_OFS_FL_ONE 3'h2
`define PIRQ_OFS_FL_TWO 3'h3
`define PIRQ_OFS_PWR 3'h4
`define PIRQ_OFS_CORE 3'h5
`define PIRQ_OFS_STAT 3'h6
// ==========================================
// Masks of implemented bits, and of software-writable first flags
`define PIRQ_TWO_MASK 8'hf5
`define PIRQ_PWR_MASK 8'h13
`define PIRQ_CORE_MASK 8'hc0
`define PIRQ_FL1_SWMASK 8'hcf
// ==========================================
// Bit positions
`define PIRQ_B_EE 7
`define PIRQ_B_AD 6
`define PIRQ_B_RX 5
`define PIRQ_B_TX 4
`define PIRQ_B_SP 3
`define PIRQ_B_C1 2
`define PIRQ_B_T2 1
`define PIRQ_B_T1 0
`define PIRQ_B_OSF 7
`define PIRQ_B_CM2 6
`define PIRQ_B_CM1 5
`define PIRQ_B_LCD 4
`define PIRQ_B_LVD 2
`define PIRQ_B_C2 0
`define PIRQ_B_SBOR 4
`define PIRQ_B_POR 1
`define PIRQ_B_BOR 0
`define PIRQ_B_GLOBAL 7
`define PIRQ_B_PERIPH 6
// ==========================================
// Reset values and codes
`define PIRQ_RST_EN 8'h00
`define PIRQ_RST_FL 8'h00
`define PIRQ_RST_SBOR 1'b1
`define PIRQ_BOCFG_SW 2'h1
`endif

// [verilog/pirq_pkg.sv]
package pirq_pkg;
   // Capture/compare unit mode
   typedef enum logic [1:0] {PIRQ_CCP_OFF, PIRQ_CCP_CAPTURE, PIRQ_CCP_COMPARE,
                             PIRQ_CCP_PWM} pirq_ccp_mode_t;
   // One-cycle event strobes from the peripherals, plus levels
   typedef struct packed {
      logic eeprom_write_done;
      logic conversion_done;
      logic serial_rx_full;      // Level
      logic serial_tx_empty;     // Level
      logic sync_port_done;
      logic capcmp_one_event;
      logic timer_two_match;
      logic timer_one_overflow;
      logic osc_fail;
      logic comparator_two_output;  // Level
      logic comparator_one_output;  // Level
      logic display_module_irq;
      logic low_voltage_detect_irq;
      logic capcmp_two_event;
   } pirq_events_t;
endpackage : pirq_pkg

// [verilog/pirq_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Peripheral side meets interrupt logic here
interface pirq_if;
   import pirq_pkg::*;
   pirq_events_t ev;                 // Peripheral events and levels
   pirq_ccp_mode_t capcmp_one_mode;  // Unit one mode
   pirq_ccp_mode_t capcmp_two_mode;  // Unit two mode
   logic serial_rx_data_read;        // Receive data register read strobe
   logic serial_tx_data_write;       // Transmit data register write strobe
   logic periph_irq_req;             // Gated request to CPU
   logic brownout_reset_enable;      // Brown-out reset arm to supervisor
   modport device (input ev, capcmp_one_mode, capcmp_two_mode, output serial_rx_data_read,
                   serial_tx_data_write, periph_irq_req, brownout_reset_enable);
   modport periph (output ev, capcmp_one_mode, capcmp_two_mode, input serial_rx_data_read,
                   serial_tx_data_write, periph_irq_req, brownout_reset_enable);
endinterface : pirq_if
`default_nettype wire

// [verilog/pirq_periph_end.sv]
`timescale 1ns/100ps
`default_nettype none
// Other party: drives events from user-side pins, reports gated request
module pirq_periph_end (
   input wire logic core_clk,                    // 25 MHz clock
   input wire logic nrst,                        // Async reset, active low
   pirq_if.periph lnk,                           // Link to interrupt logic
   input wire pirq_pkg::pirq_events_t ev_in,     // Peripheral events
   input wire pirq_pkg::pirq_ccp_mode_t mode_one,  // Unit one mode
   input wire pirq_pkg::pirq_ccp_mode_t mode_two,  // Unit two mode
   output logic rx_read_seen,                    // Receive register was read
   output logic tx_write_seen,                   // Transmit register was written
   output logic irq_out,                         // Request to CPU
   output logic bor_armed                        // Brown-out reset armed
);
   import pirq_pkg::*;
   // ==========================================
   // Registered event drive; data outputs from flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lnk.ev <= '0;
         lnk.capcmp_one_mode <= PIRQ_CCP_OFF;
         lnk.capcmp_two_mode <= PIRQ_CCP_OFF;
         rx_read_seen <= 1'b0;
         tx_write_seen <= 1'b0;
      end else begin
         lnk.ev <= ev_in;
         lnk.capcmp_one_mode <= mode_one;
         lnk.capcmp_two_mode <= mode_two;
         rx_read_seen <= lnk.serial_rx_data_read;
         tx_write_seen <= lnk.serial_tx_data_write;
      end
   end
   // Request and arm are levels passed through
   assign irq_out = lnk.periph_irq_req;
   assign bor_armed = lnk.brownout_reset_enable;
endmodule : pirq_periph_end
`default_nettype wire

// [verilog/pirq_device_end.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pirq_defs.svh"
// Interrupt enables, flags and power control with Avalon-MM slave
module pirq_device_end (
   input wire logic core_clk,              // 25 MHz clock
   input wire logic nrst,                  // Async reset, active low
   pirq_if.device lnk,                     // Link to peripherals
   input wire logic [2:0] avs_address,     // Word address
   input wire logic avs_read,              // Read request
   input wire logic avs_write,             // Write request
   input wire logic [31:0] avs_writedata,  // Write data
   input wire logic [3:0] avs_byteenable,  // Byte enables
   output logic [31:0] avs_readdata,       // Read data
   output logic avs_waitrequest,           // Stall
   output logic avs_response_err,          // Unmapped access flag
   input wire logic por_event,             // Power-on reset happened
   input wire logic bor_event,             // Brown-out reset happened
   input wire logic [1:0] brownout_config_field  // Config word field
);
   import pirq_pkg::*;
   // ==========================================
   // Helper functions
   // Capture/compare flags count only in capture or compare mode
   function automatic logic ccp_flag_mode(input pirq_ccp_mode_t mode);
      ccp_flag_mode = (mode == PIRQ_CCP_CAPTURE) || (mode == PIRQ_CCP_COMPARE);
   endfunction : ccp_flag_mode
   // Word index match for one register slot
   function automatic logic slot_hit(input logic [2:0] addr, input logic [2:0] slot);
      slot_hit = (addr == slot);
   endfunction : slot_hit
   // Eight-bit register placed in the low lane, upper lanes zero
   function automatic logic [31:0] widen(input logic [7:0] value);
      widen = {24'h0, value};
   endfunction : widen
   // ==========================================
   // Registers and next values
   // All registers are one byte wide; the bus only ever uses the low lane
   logic [7:0] en_one_q; // First enable register
   logic [7:0] en_two_q; // Second enable register, gaps held low
   logic [7:0] fl_one_q; // First flag register
   logic [7:0] fl_two_q; // Second flag register, gaps held low
   logic [7:0] fl_one_d; // Next first flags
   logic [7:0] fl_two_d; // Next second flags
   logic [7:0] core_q; // Global and peripheral gate bits
   logic sbor_q; // Software brown-out enable
   logic por_q; // Power-on status, low after power-on
   logic bor_q; // Brown-out status, low after brown-out
   logic cmp_one_q; // Comparator one output last cycle
   logic cmp_two_q; // Comparator two output last cycle
   logic ack_q; // Answer cycle of a bus access
   logic [31:0] rdata_q; // Registered read data
   logic [31:0] rdata_d; // Selected read data
   // ==========================================
   // Bus decode
   // One wait state per access: the request is taken in its first cycle
   // and answered in the next, when the stall drops
   // Writes land on the answer edge, the same edge the master completes on
   wire access = (avs_read | avs_write) & ~ack_q; // First cycle of a request
   wire rd_take = access & avs_read; // Read data captured here
   wire wr = avs_write & ack_q & avs_byteenable[0]; // Write edge, lane 0 only
   wire [7:0] wd = avs_writedata[7:0]; // Only the low lane carries data
   wire wr_en1 = wr && slot_hit(avs_address, `PIRQ_OFS_EN_ONE); // First enables
   wire wr_en2 = wr && slot_hit(avs_address, `PIRQ_OFS_EN_TWO); // Second enables
   wire wr_fl1 = wr && slot_hit(avs_address, `PIRQ_OFS_FL_ONE); // First flags
   wire wr_fl2 = wr && slot_hit(avs_address, `PIRQ_OFS_FL_TWO); // Second flags
   wire wr_pwr = wr && slot_hit(avs_address, `PIRQ_OFS_PWR); // Power control
   wire wr_core = wr && slot_hit(avs_address, `PIRQ_OFS_CORE); // Gate bits
   wire mapped = avs_address <= `PIRQ_OFS_STAT; // Slots 0 to 6 exist
   // Handshake outputs are combinational
   assign avs_waitrequest = access;
   assign avs_readdata = rdata_q;
   // Unmapped slot reported while its answer stands
   assign avs_response_err = ack_q & ~mapped;
   // ==========================================
   // Event decode
   // Comparator history resets low, matching the idle output level,
   // so no false change is seen just after reset
   wire cap1 = ccp_flag_mode(lnk.capcmp_one_mode);
   wire cap2 = ccp_flag_mode(lnk.capcmp_two_mode);
   wire cmp_one_edge = lnk.ev.comparator_one_output ^ cmp_one_q;
   wire cmp_two_edge = lnk.ev.comparator_two_output ^ cmp_two_q;
   // First flag sources; receive and transmit are levels, handled below
   wire [7:0] set_one = {lnk.ev.eeprom_write_done,
                         lnk.ev.conversion_done,
                         2'b00,
                         lnk.ev.sync_port_done,
                         lnk.ev.capcmp_one_event & cap1,
                         lnk.ev.timer_two_match,
                         lnk.ev.timer_one_overflow};
   // Second flag sources; gaps stay zero
   wire [7:0] set_two = {lnk.ev.osc_fail,
                         cmp_two_edge,
                         cmp_one_edge,
                         lnk.ev.display_module_irq,
                         1'b0,
                         lnk.ev.low_voltage_detect_irq,
                         1'b0,
                         lnk.ev.capcmp_two_event & cap2};
   // ==========================================
   // Next flags: a hardware set wins over a software clear in the same
   // cycle, so an event that lands during the clear is never lost
   // Enables play no part here; flags record events whatever they hold
   always_comb begin
      fl_one_d = fl_one_q;
      fl_two_d = fl_two_q;
      if (wr_fl1) fl_one_d = wd & `PIRQ_FL1_SWMASK;
      if (wr_fl2) fl_two_d = wd & `PIRQ_TWO_MASK;
      fl_one_d = fl_one_d | set_one;
      fl_two_d = fl_two_d | set_two;
      // Receive and transmit follow their buffer levels
      fl_one_d[`PIRQ_B_RX] = lnk.ev.serial_rx_full;
      fl_one_d[`PIRQ_B_TX] = lnk.ev.serial_tx_empty;
   end
   // ==========================================
   // Read selection; captured in the request cycle, shown in the answer
   always_comb begin
      rdata_d = 32'h0;
      unique case (avs_address)
         `PIRQ_OFS_EN_ONE: rdata_d = widen(en_one_q);
         `PIRQ_OFS_EN_TWO: rdata_d = widen(en_two_q);
         `PIRQ_OFS_FL_ONE: rdata_d = widen(fl_one_q);
         `PIRQ_OFS_FL_TWO: rdata_d = widen(fl_two_q);
         `PIRQ_OFS_PWR: rdata_d = widen({3'h0, sbor_q, 2'h0, por_q, bor_q});
         `PIRQ_OFS_CORE: rdata_d = widen(core_q);
         `PIRQ_OFS_STAT: rdata_d = widen({7'h0, lnk.periph_irq_req});
         default: rdata_d = 32'h0; // Unmapped reads zero
      endcase
   end
   // ==========================================
   // Bus handshake and read data
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q <= access;
         // Read data stands until the next read
         if (rd_take) begin
            rdata_q <= rdata_d;
         end
      end
   end
   // Enable and gate registers; gaps in the second enables are dropped
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         en_one_q <= `PIRQ_RST_EN;
         en_two_q <= `PIRQ_RST_EN;
         core_q <= 8'h00;
      end else begin
         if (wr_en1) en_one_q <= wd;
         if (wr_en2) en_two_q <= wd & `PIRQ_TWO_MASK;
         if (wr_core) core_q <= wd & `PIRQ_CORE_MASK;
      end
   end
   // Sticky flags and comparator history
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fl_one_q <= `PIRQ_RST_FL;
         fl_two_q <= `PIRQ_RST_FL;
         cmp_one_q <= 1'b0;
         cmp_two_q <= 1'b0;
      end else begin
         fl_one_q <= fl_one_d;
         fl_two_q <= fl_two_d;
         cmp_one_q <= lnk.ev.comparator_one_output;
         cmp_two_q <= lnk.ev.comparator_two_output;
      end
   end
   // Power control: software brown-out enable and reset-cause status
   // Status bits read low after reset; software sets them to mark a clean start
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sbor_q <= `PIRQ_RST_SBOR;
         por_q <= 1'b0;
         bor_q <= 1'b0;
      end else begin
         if (wr_pwr) begin
            sbor_q <= wd[`PIRQ_B_SBOR];
         end
         // Reset events clear, software sets
         if (por_event) begin
            por_q <= 1'b0;
         end else if (wr_pwr) begin
            por_q <= wd[`PIRQ_B_POR];
         end
         // A power-on also counts as a brown-out for the status bit
         if (bor_event | por_event) begin
            bor_q <= 1'b0;
         end else if (wr_pwr) begin
            bor_q <= wd[`PIRQ_B_BOR];
         end
      end
   end
   // ==========================================
   // Serial strobes
   // The receive and transmit data registers live in the serial unit, which
   // clears its own levels; these strobes are kept for the link and stay low
   assign lnk.serial_rx_data_read = 1'b0;
   assign lnk.serial_tx_data_write = 1'b0;
   // ==========================================
   // Request gating
   // A flag set while its enable is off stays pending and fires on enable
   wire [7:0] live_one = fl_one_q & en_one_q;
   wire [7:0] live_two = fl_two_q & en_two_q;
   wire any_src = (|live_one) | (|live_two);
   wire periph_gate = core_q[`PIRQ_B_PERIPH];
   wire global_gate = core_q[`PIRQ_B_GLOBAL];
   assign lnk.periph_irq_req = any_src & periph_gate & global_gate;
   // ==========================================
   // Brown-out arm
   // The soft bit is obeyed only in the software-controlled configuration
   wire bor_sw_mode = brownout_config_field == `PIRQ_BOCFG_SW;
   assign lnk.brownout_reset_enable = bor_sw_mode ? sbor_q : brownout_config_field[1];
endmodule : pirq_device_end
`default_nettype wire

// [testbench/pirq_link_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// ====
// Link and bus watcher
module pirq_link_sva (
   input wire logic core_clk, // Clock
   input wire logic nrst, // Reset
   input wire logic periph_irq_req, // Request
   input wire logic brownout_reset_enable, // Arm
   input wire logic [2:0] avs_address, // Addr
   input wire logic avs_read, // Rd
   input wire logic avs_write, // Wr
   input wire logic [31:0] avs_writedata, // Wdata
   input wire logic [3:0] avs_byteenable, // Lanes
   input wire logic [31:0] avs_readdata, // Rdata
   input wire logic avs_waitrequest, // Stall
   input wire logic [1:0] brownout_config_field // Field
);
   logic [1:0] gate_q; // Both gates, as last written
   wire gate_wr = avs_write && avs_address == 3'h5; // Gate write under way
   // Mirror takes the write on the same answer edge as the design; a live gate write is excused anyway
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         gate_q <= 2'h0;
      end else if (gate_wr && !avs_waitrequest && avs_byteenable[0]) begin
         gate_q <= avs_writedata[7:6];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ans; avs_read && !avs_waitrequest; endsequence
   property p_wait_once; s_req |=> !avs_waitrequest; endproperty
   a_wait_once: assert property (p_wait_once) else $error("stall too long");
   property p_wait_idle; !avs_read && !avs_write |-> !avs_waitrequest; endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("stall while idle");
   property p_upper; s_ans |-> avs_readdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_two_gaps;
      s_ans ##0 (avs_address inside {3'h1, 3'h3}) |-> avs_readdata[3] == 1'b0 && !avs_readdata[1];
   endproperty
   a_two_gaps: assert property (p_two_gaps) else $error("gap bit set");
   property p_pwr_gaps;
      s_ans ##0 avs_address == 3'h4 |-> avs_readdata[7:5] == 3'h0 && avs_readdata[3:2] == 2'h0;
   endproperty
   a_pwr_gaps: assert property (p_pwr_gaps) else $error("power gap set");
   property p_bor_arm;
      (brownout_config_field != 2'h1 && $stable(brownout_config_field)) [*2]
         |-> brownout_reset_enable == brownout_config_field[1];
   endproperty
   a_bor_arm: assert property (p_bor_arm) else $error("arm ignores field");
   property p_req_gate; periph_irq_req |-> gate_q == 2'h3 || gate_wr; endproperty
   a_req_gate: assert property (p_req_gate) else $error("request while gated");
   property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : pirq_link_sva
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ====
// Bench for both ends
module tb_top;
   import pirq_pkg::*;
   logic core_clk = 1'b0; // 25 MHz
   logic nrst = 1'b0; // Reset
   logic [2:0] avs_address = 3'h0; // Bus
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h1; // Lane 0 only
   logic [31:0] avs_readdata;
   logic avs_waitrequest, rx_seen, tx_seen, irq_out, bor_armed;
   logic por_event = 1'b0;
   logic bor_event = 1'b0;
   logic [1:0] bor_cfg = 2'h1; // Config field
   pirq_events_t ev_in = '0; // Peripheral stimulus
   pirq_ccp_mode_t mode_one = PIRQ_CCP_CAPTURE;
   pirq_ccp_mode_t mode_two = PIRQ_CCP_COMPARE; // Unit two mode
   logic resp_err; // Unmapped access flag
   logic rsp_q; // Flag seen at the last answer
   int err_count = 0;
   int cmp_count = 0;
   logic [7:0] rd_q; // Last read byte
   pirq_if lnk ();
   always #20 core_clk = ~core_clk;
   pirq_periph_end u_pirq_periph_end (.core_clk(core_clk), .nrst(nrst), .lnk(lnk),
      .ev_in(ev_in), .mode_one(mode_one), .mode_two(mode_two), .rx_read_seen(rx_seen),
      .tx_write_seen(tx_seen), .irq_out(irq_out), .bor_armed(bor_armed));
   pirq_device_end u_pirq_device_end (.core_clk(core_clk), .nrst(nrst), .lnk(lnk),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response_err(resp_err), .por_event(por_event),
      .bor_event(bor_event), .brownout_config_field(bor_cfg));
   pirq_link_sva u_pirq_link_sva (.core_clk(core_clk), .nrst(nrst),
      .periph_irq_req(lnk.periph_irq_req), .brownout_reset_enable(lnk.brownout_reset_enable),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .brownout_config_field(bor_cfg));
   // ====
   // Shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd_q = avs_readdata[7:0];
      rsp_q = resp_err;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h0);
      chk(rd_q, exp);
   endtask : rchk
   task automatic pulse(input int i);
      ev_in[i] <= 1'b1;
      tick(1);
      ev_in[i] <= 1'b0;
      tick(3);
   endtask : pulse
   // ====
   // Scenarios
   task automatic t_reset;
      rchk(3'h0, 8'h00);
      rchk(3'h1, 8'h00);
      rchk(3'h4, 8'h10);
      chk({7'h0, rsp_q}, 8'h00); // Mapped answer
      chk({6'h0, rx_seen, tx_seen}, 8'h00);
      rchk(3'h7, 8'h00); // Unmapped place
      chk({7'h0, rsp_q}, 8'h01); // Unmapped answer flagged
      bus(1'b1, 3'h0, 8'hff);
      rchk(3'h0, 8'hff);
      bus(1'b1, 3'h1, 8'hff);
      rchk(3'h1, 8'hf5);
      bus(1'b1, 3'h4, 8'hff);
      rchk(3'h4, 8'h13);
      bus(1'b1, 3'h0, 8'h00);
      bus(1'b1, 3'h1, 8'h00);
      $display("reset and mask test done");
   endtask : t_reset
   // Each source with every enable off; receive and transmit flags must follow their input
   task automatic t_flags;
      int pos[14] = '{0, 2, 4, 5, 6, 7, 0, 1, 2, 3, 4, 5, 6, 7};
      logic [2:0] a;
      for (int i = 0; i < 14; i++) begin
         a = (i > 5) ? 3'h2 : 3'h3;
         ev_in[i] <= 1'b1;
         tick(3);
         rchk(a, 8'h1 << pos[i]);
         chk({7'h0, irq_out}, 8'h00);
         ev_in[i] <= 1'b0;
         tick(3);
         rchk(a, (i == 10 || i == 11) ? 8'h00 : 8'h1 << pos[i]);
         bus(1'b1, a, 8'h00);
         rchk(a, 8'h00);
      end
      for (int m = 0; m < 4; m++) begin
         mode_one <= pirq_ccp_mode_t'(m);
         mode_two <= pirq_ccp_mode_t'(m);
         tick(2);
         pulse(8);
         pulse(0);
         rchk(3'h2, (m == 1 || m == 2) ? 8'h04 : 8'h00);
         rchk(3'h3, (m == 1 || m == 2) ? 8'h01 : 8'h00);
         bus(1'b1, 3'h2, 8'h00);
         bus(1'b1, 3'h3, 8'h00);
      end
      $display("flag test done");
   endtask : t_flags
   task automatic t_request;
      bus(1'b1, 3'h0, 8'h01);
      bus(1'b1, 3'h5, 8'hc0);
      pulse(6);
      chk({7'h0, irq_out}, 8'h01);
      rchk(3'h6, 8'h01);
      bus(1'b1, 3'h5, 8'h80);
      tick(2);
      chk({7'h0, irq_out}, 8'h00);
      bus(1'b1, 3'h5, 8'h40);
      tick(2);
      chk({7'h0, irq_out}, 8'h00);
      bus(1'b1, 3'h2, 8'h00);
      bus(1'b1, 3'h5, 8'hc0);
      pulse(12);
      chk({7'h0, irq_out}, 8'h00);
      $display("request test done");
   endtask : t_request
   task automatic t_power;
      for (int f = 0; f < 4; f++) begin
         bor_cfg <= f[1:0];
         bus(1'b1, 3'h4, 8'h03);
         tick(2);
         chk({7'h0, bor_armed}, (f == 1) ? 8'h00 : {7'h0, f[1]});
         bus(1'b1, 3'h4, 8'h13);
         tick(2);
         chk({7'h0, bor_armed}, (f == 1) ? 8'h01 : {7'h0, f[1]});
      end
      bor_event <= 1'b1;
      tick(1);
      bor_event <= 1'b0;
      rchk(3'h4, 8'h12);
      por_event <= 1'b1;
      tick(1);
      por_event <= 1'b0;
      rchk(3'h4, 8'h10);
      $display("power test done");
   endtask : t_power
   task automatic finish_test;
      $display("checks %0d, wrong %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   // Main sequence, then a watchdog well past its length
   initial begin
      tick(6);
      nrst <= 1'b1;
      t_reset();
      t_flags();
      t_request();
      t_power();
      finish_test();
   end
   initial begin
      #(40 * 20000);
      err_count++;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
